// File: hdl/dpt_timer.sv
`timescale 1ns/100ps
// Behaviour
// - counter decrements on each selected prescaler tick; software loads and reads it.
// - prescaler input is internal clock divided by twelve, no other source.
// - seven-bit prescaler counts down on its input tick.
// - counter tick taken from prescaler input or a prescaler bit per tap select.
// - run bit clear forces prescaler to all ones and stops counter.
// - while running, software may load prescaler with any value up to 7Fh.
// - zero flag sets when counter decrements to zero.
// - flag with interrupt enable raises interrupt request on vector four.
// - flag also sets on writing 00h to counter or one to bit 7.
// - reset loads counter FFh, prescaler 7Fh, clears control/status register.
// - count register at data address D3h, read and write.
// - prescaler state readable at data address D2h.
// - enabled interrupt wakes processor from wait since timer keeps counting.
// - a counter write in the same cycle as reaching zero wins; no flag unless the write is 00h.
// - three-bit tap select gives divide by 1 up to 128 in powers of two.
// - control/status at D4h: flag 7, enable 6, run 3, tap 2..0.
module dpt_timer (
   input wire clk,
   input wire rstn,
   input wire [dpt_pkg::DPT_ADDR_W-1:0] addr,
   input wire wr_en,
   input wire [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic irq_req,
   output logic [2:0] irq_vector,
   output logic wake_req
);
   import dpt_pkg::*;
   logic [3:0] div_q;
   logic [3:0] div_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic zero_q;
   logic zero_d;
   logic irq_en_q;
   logic run_q;
   logic [2:0] tap_q;
   logic [1:0] csr_spare_q;
   logic wr_psc;
   logic wr_cnt;
   logic wr_csr;
   logic div_tick;
   logic cnt_tick;
   logic hit_zero;
   logic sw_set;
   logic [7:0] csr_view;
   logic [7:0] rd_d;

   dpt_tick_if tick_bus ();

   dpt_prescaler u_psc (
      .clk(clk),
      .rstn(rstn),
      .bus(tick_bus)
   );

   assign wr_psc = wr_en && (addr == DPT_ADDR_PSC);
   assign wr_cnt = wr_en && (addr == DPT_ADDR_CNT);
   assign wr_csr = wr_en && (addr == DPT_ADDR_CSR);

   // fixed divide by twelve; cleared to zero while stopped so the phase restarts clean
   assign div_tick = run_q && (div_q == DPT_PRE_LAST);
   assign div_d = !run_q ? 4'h0 : div_tick ? 4'h0 : div_q + 4'h1;

   assign tick_bus.in_tick = div_tick;
   assign tick_bus.run = run_q;
   // a load is only honoured while running, otherwise the prescaler stays at 7Fh
   assign tick_bus.load = wr_psc && run_q;
   assign tick_bus.load_val = wr_data[6:0];
   assign tick_bus.tap = tap_q;
   assign cnt_tick = tick_bus.out_tick && run_q;

   // write beats the decrement, so no flag from a simultaneous zero
   assign cnt_d = wr_cnt ? wr_data :
                  cnt_tick ? cnt_q - 8'h01 : cnt_q;
   assign hit_zero = cnt_tick && !wr_cnt && (cnt_q == 8'h01);
   assign sw_set = (wr_cnt && (wr_data == 8'h00)) ||
                   (wr_csr && wr_data[DPT_BIT_ZERO]);
   // hardware set beats software clear in the same cycle
   assign zero_d = hit_zero || sw_set ? 1'b1 :
                   wr_csr ? wr_data[DPT_BIT_ZERO] : zero_q;

   assign csr_view = {zero_q, irq_en_q, csr_spare_q, run_q, tap_q};
   assign rd_d = (addr == DPT_ADDR_PSC) ? {1'b0, tick_bus.value} :
                 (addr == DPT_ADDR_CNT) ? cnt_q :
                 (addr == DPT_ADDR_CSR) ? csr_view : 8'h00;

   // level request; stays up until software clears the flag or the enable bit
   assign irq_req = zero_q && irq_en_q;
   assign irq_vector = DPT_IRQ_VECTOR;
   assign wake_req = irq_req;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 4'h0;
         cnt_q <= DPT_CNT_RESET;
      end else begin
         div_q <= div_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         zero_q <= DPT_CSR_RESET[DPT_BIT_ZERO];
         irq_en_q <= DPT_CSR_RESET[DPT_BIT_IRQ_EN];
         run_q <= DPT_CSR_RESET[DPT_BIT_RUN];
         tap_q <= DPT_CSR_RESET[2:0];
         csr_spare_q <= DPT_CSR_RESET[5:4];
      end else begin
         zero_q <= zero_d;
         if (wr_csr) begin
            irq_en_q <= wr_data[DPT_BIT_IRQ_EN];
            run_q <= wr_data[DPT_BIT_RUN];
            tap_q <= wr_data[2:0];
            csr_spare_q <= wr_data[5:4];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_d;
      end
   end
endmodule // dpt_timer

// File: hdl/dpt_pkg.sv
package dpt_pkg;
   localparam int DPT_CNT_W = 8;
   localparam int DPT_PSC_W = 7;
   localparam int DPT_ADDR_W = 8;
   localparam logic [7:0] DPT_ADDR_PSC = 8'hd2;
   localparam logic [7:0] DPT_ADDR_CNT = 8'hd3;
   localparam logic [7:0] DPT_ADDR_CSR = 8'hd4;
   localparam logic [7:0] DPT_CNT_RESET = 8'hff;
   localparam logic [6:0] DPT_PSC_RESET = 7'h7f;
   localparam logic [7:0] DPT_CSR_RESET = 8'h00;
   localparam int DPT_BIT_ZERO = 7;
   localparam int DPT_BIT_IRQ_EN = 6;
   localparam int DPT_BIT_RUN = 3;
   localparam int DPT_TAP_LSB = 0;
   localparam int DPT_TAP_W = 3;
   localparam int DPT_PRE_DIV = 12;
   localparam logic [3:0] DPT_PRE_LAST = 4'(DPT_PRE_DIV - 1);
   localparam logic [2:0] DPT_IRQ_VECTOR = 3'h4;
endpackage

// File: hdl/dpt_tick_if.sv
`timescale 1ns/100ps
interface dpt_tick_if;
   logic in_tick;
   logic run;
   logic load;
   logic [6:0] load_val;
   logic [2:0] tap;
   logic [6:0] value;
   logic out_tick;
   modport ctl (output in_tick, run, load, load_val, tap, input value, out_tick);
   modport prescaler_value (input in_tick, run, load, load_val, tap, output value, out_tick);
endinterface

// File: hdl/dpt_prescaler.sv
`timescale 1ns/100ps
module dpt_prescaler (
   input wire clk,
   input wire rstn,
   dpt_tick_if.prescaler_value bus
);
   import dpt_pkg::*;
   logic [6:0] val_q;
   logic [6:0] val_d;
   logic [7:0] taps_old;
   logic [7:0] taps_new;
   logic step;
   // the prescaler steps down on each input tick while running
   assign step = bus.run && bus.in_tick;
   assign val_d = !bus.run ? DPT_PSC_RESET :
                  bus.load ? bus.load_val :
                  step ? val_q - 7'h01 : val_q;
   // tap 0 is the input tick itself; tap n is a rising edge of bit n-1
   assign taps_old = {val_q, 1'b0};
   assign taps_new = {val_d, 1'b0};
   assign bus.out_tick = (bus.tap == 3'h0) ? step :
                         (step && !taps_old[bus.tap] && taps_new[bus.tap]);
   assign bus.value = val_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         val_q <= DPT_PSC_RESET;
      end else begin
         val_q <= val_d;
      end
   end
endmodule // dpt_prescaler

// File: sim/dpt_timer_monitor.sv
`timescale 1ns/100ps
module dpt_timer_monitor (
   input logic clk,
   input logic rstn,
   input logic [7:0] addr,
   input logic wr_en,
   input logic [7:0] wr_data,
   input logic [7:0] rd_data,
   input logic irq_req,
   input logic [2:0] irq_vector,
   input logic wake_req
);
   import dpt_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire csr_wr = wr_en && addr == DPT_ADDR_CSR;
   sequence s_zero_wr;
      wr_en && addr == DPT_ADDR_CNT && wr_data == 8'h00 ##1 !wr_en && addr == DPT_ADDR_CSR;
   endsequence
   sequence s_csr_wr;
      csr_wr ##1 !wr_en && addr == DPT_ADDR_CSR;
   endsequence
   a_irq_vector: assert property (irq_vector == DPT_IRQ_VECTOR) else $error("vector");
   a_wake_irq: assert property (wake_req == irq_req) else $error("wake");
   a_psc_msb: assert property ($past(addr) == DPT_ADDR_PSC |-> !rd_data[7]) else $error("msb");
   a_zero_write_flag: assert property (s_zero_wr |=> rd_data[7]) else $error("zero wr");
   a_csr_readback: assert property (s_csr_wr |=> rd_data[6:0] == $past(wr_data[6:0], 2))
      else $error("csr");
   a_csr_flag_en: assert property ($past(addr) == DPT_ADDR_CSR && $past(irq_req)
      |-> rd_data[7:6] == 2'b11) else $error("flag bits");
   a_irq_holds: assert property (irq_req && !csr_wr |=> irq_req) else $error("irq drop");
   a_irq_fall_wr: assert property ($fell(irq_req) |-> $past(csr_wr)) else $error("irq fall");
endmodule // dpt_timer_monitor
bind dpt_timer dpt_timer_monitor mon_u (.clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en),
   .wr_data(wr_data), .rd_data(rd_data), .irq_req(irq_req), .irq_vector(irq_vector),
   .wake_req(wake_req));

// File: sim/test_dpt_timer.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %0t %h", $time, g); end end
module test_dpt_timer;
   import dpt_pkg::*;
   logic clk = 0, rstn = 0, wr_en = 0, irq_req, wake_req;
   logic [7:0] addr = '0, wr_data = '0, v, rd_data;
   logic [2:0] irq_vector;
   int err_count = 0, num_checks = 0, c, p;
   always #20 clk = ~clk;
   dpt_timer dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
      .rd_data(rd_data), .irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req));
   function automatic int period(input int t);
      return DPT_PRE_DIV << t;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin addr <= a; wr_en <= 1'b1; wr_data <= d; end
      @(posedge clk) wr_en <= 1'b0;
      // let the write settle before any caller looks at the outputs
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk) addr <= a;
      @(posedge clk) #1;
   endtask
   task close_out;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      close_out;
   end
   initial begin
      void'($urandom(32'h7bc0_2b89));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(DPT_ADDR_PSC);
      `CHK(rd_data, {1'b0, DPT_PSC_RESET})
      rd(DPT_ADDR_CNT);
      `CHK(rd_data, DPT_CNT_RESET)
      rd(DPT_ADDR_CSR);
      `CHK(rd_data, DPT_CSR_RESET)
      rd(8'hd5);
      `CHK(rd_data, 8'h00)
      wr(DPT_ADDR_PSC, 8'h11);
      rd(DPT_ADDR_PSC);
      `CHK(rd_data, 8'h7f)
      wr(DPT_ADDR_CSR, 8'hf0);
      `CHK(irq_req, 1'b1)
      wr(DPT_ADDR_CSR, 8'h40);
      `CHK(irq_req, 1'b0)
      wr(DPT_ADDR_CNT, 8'h00);
      `CHK(irq_req, 1'b1)
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom_range(2, 255));
         wr(DPT_ADDR_CNT, v);
         rd(DPT_ADDR_CNT);
         `CHK(rd_data, v)
      end
      for (int t = 0; t < 8; t++) begin
         p = period(t);
         wr(DPT_ADDR_CSR, 8'h00);
         wr(DPT_ADDR_CNT, 8'h02);
         wr(DPT_ADDR_CSR, 8'(8'h48 | t));
         c = 0;
         while (irq_req !== 1'b1 && c < 4 * p) begin
            @(posedge clk);
            c++;
         end
         `CHK(c >= 2 * p - 3 && c <= 2 * p + 3, 1'b1)
         rd(DPT_ADDR_CNT);
         `CHK(rd_data, 8'h00)
         repeat (p) @(posedge clk);
         rd(DPT_ADDR_CNT);
         `CHK(rd_data, 8'hff)
      end
      v = 8'($urandom_range(0, 127));
      wr(DPT_ADDR_PSC, v);
      rd(DPT_ADDR_PSC);
      // prescaler is seven bits, so a load of zero may already have wrapped to 7Fh
      `CHK(rd_data === {1'b0, v[6:0]} || rd_data === {1'b0, 7'(v[6:0] - 7'h01)}, 1'b1)
      close_out;
   end
endmodule // test_dpt_timer
